// ==== core/motor_ctrl_pkg.sv ====
// shared constants, encodings and carriers for the dual motor control block
package motor_ctrl_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 100;
  localparam int WAKE_TIME_NS      = 1000000;   // 1 ms
  localparam int WAKE_CYCLES_DEF   = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int DEAD_TIME_NS      = 200;
  localparam int ANALOG_BLANK_NS   = 300;
  localparam int DEAD_CYC_I        =
    (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANALOG_BLANK_I    =
    (ANALOG_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_W            = 16;
  localparam int DEAD_W            = 2;
  localparam int BLANK_W           = 3;
  localparam logic [DEAD_W-1:0]  DEAD_CYCLES   = DEAD_W'(DEAD_CYC_I);
  localparam logic [BLANK_W-1:0] ANALOG_BLANK  = BLANK_W'(ANALOG_BLANK_I);
  localparam logic [BLANK_W-1:0] BLANK_OSC_CYC = 3'h4;
  localparam logic [2:0]         STRAP_LAST    = 3'h5;

  // ****************************************************************
  // electrical angle, 16 positions of 22.5 degrees
  // ****************************************************************
  localparam int             ANGLE_W       = 4;
  localparam logic [3:0]     ANGLE_INIT    = 4'h2;  // 45 degrees
  localparam logic [3:0]     STEP_FULL     = 4'h4;
  localparam logic [3:0]     STEP_HALF     = 4'h2;
  localparam logic [3:0]     STEP_QUARTER  = 4'h1;
  localparam logic [3:0]     QUARTER_TURN  = 4'h4;
  localparam logic [1:0]     RES_FIXED     = 2'h0;
  localparam logic [1:0]     RES_HALF      = 2'h1;
  localparam logic [1:0]     RES_FULL      = 2'h2;

  // ****************************************************************
  // synchronised input vector layout
  // ****************************************************************
  localparam int PAIR_BITS = 7;
  localparam int IDX_STEP  = 0;
  localparam int IDX_EN    = 1;
  localparam int IDX_DIR   = 2;
  localparam int IDX_HI    = 3;
  localparam int IDX_LO    = 4;
  localparam int IDX_BLK   = 5;
  localparam int IDX_LIM   = 6;
  localparam int IDX_SLEEP = 14;
  localparam int IDX_TSD   = 15;
  localparam int IDX_ISD   = 16;
  localparam int IDX_OSC   = 17;
  localparam int IDX_DRIVE_MODE_SEL0 = 18;
  localparam int IN_W      = 19;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_STEPS    = 4'h8;
  localparam logic [1:0]  CTRL_RESET   = 2'h3;

  typedef enum logic [1:0] {
    CMD_OFF   = 2'b00,
    CMD_FWD   = 2'b01,
    CMD_REV   = 2'b10,
    CMD_BRAKE = 2'b11
  } bridge_cmd_e;

  typedef enum logic [1:0] {
    DECAY_NONE   = 2'b00,
    DECAY_MIX_HI = 2'b01,   // 37.5 percent
    DECAY_MIX_LO = 2'b10    // 12.5 percent
  } decay_e;

  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_WAKE  = 2'b01,
    PWR_RUN   = 2'b10
  } pwr_e;

  // one bridge's pin drive
  typedef struct packed {
    logic pos;
    logic neg;
    logic pos_oe;
    logic neg_oe;
  } bridge_out_s;

endpackage

// ==== core/dual_motor_ctrl.sv ====
// dual h-bridge stepper and brushed dc control logic with avalon registers
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module dual_motor_ctrl
  import motor_ctrl_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input  wire logic              mclk,                          // 10 MHz
  input  wire logic              rst,                           // async
  input  wire logic              step_pulse_first_pair,         // step clk
  input  wire logic              step_pulse_second_pair,        // step clk
  input  wire logic              output_enable_first_pair,      // en/brake
  input  wire logic              output_enable_second_pair,     // en/brake
  input  wire logic              direction_first_pair,          // dir
  input  wire logic              direction_second_pair,         // dir
  input  wire logic              resolution_sel_hi_first_pair,  // res/in1
  input  wire logic              resolution_sel_lo_first_pair,  // res
  input  wire logic              resolution_sel_hi_second_pair, // res/in1
  input  wire logic              resolution_sel_lo_second_pair, // res
  input  wire logic              blank_decay_sel_first_pair,    // select
  input  wire logic              blank_decay_sel_second_pair,   // select
  input  wire logic              limit_hit_first_pair,          // comp
  input  wire logic              limit_hit_second_pair,         // comp
  input  wire logic              chopper_oscillator,            // ref osc
  input  wire logic              thermal_shutdown,              // fault
  input  wire logic              overcurrent_detect,            // fault
  input  wire logic              sleep_n,                       // low power
  input  wire logic              drive_mode_sel0,               // strap
  output bridge_out_s [3:0]      bridge_out,                    // pins
  output decay_e      [1:0]      decay_mode,                    // per pair
  output logic                   angle_monitor_first_pair,      // at 45
  output logic                   fault_alert_o,                 // always 0
  output logic                   fault_alert_oe,                // pull low
  input  wire logic [ADDR_W-1:0] address,                       // byte addr
  input  wire logic              read,                          // strobe
  input  wire logic              write,                         // strobe
  input  wire logic [3:0]        byteenable,                    // lanes
  input  wire logic [31:0]       writedata,                     // data
  output logic      [31:0]       readdata,                      // data
  output logic                   waitrequest                    // stall
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [IN_W-1:0]                sync1;
    logic [IN_W-1:0]                sync2;
    logic [IN_W-1:0]                sync3;
    logic [IN_W-1:0]                filt;
    logic [IN_W-1:0]                prev;
    pwr_e                           pwr;
    logic [WAKE_W-1:0]              wake_cnt;
    logic [2:0]                     strap_cnt;
    logic                           strap_done;
    logic                           dc_mode;
    logic [1:0][ANGLE_W-1:0]        angle;
    logic [1:0][15:0]               step_cnt;
    logic [1:0]                     gate;
    logic [3:0][1:0]                applied;
    logic [3:0][DEAD_W-1:0]         dead;
    logic [1:0][BLANK_W-1:0]        blank;
    logic [1:0]                     blank_osc;
    logic [1:0][1:0]                decay;
    bridge_out_s [3:0]              outs;
    logic                           mon;
    logic                           alert_oe;
    logic                           ack;
    logic [31:0]                    rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    pwr:      PWR_SLEEP,
    angle:    {ANGLE_INIT, ANGLE_INIT},
    gate:     CTRL_RESET,
    alert_oe: 1'b1,      // alert reads low while held in reset
    default:  '0
  };

  state_s s_reg;
  state_s s_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // sign of the cosine at a 22.5 degree index; zero crossing = off
  function automatic logic [1:0] phase_cmd(input logic [3:0] a);
    logic [1:0] c;
    c = CMD_REV;
    if (a == QUARTER_TURN || a == (4'h0 - QUARTER_TURN))
      c = CMD_OFF;
    else if (a < QUARTER_TURN || a > (4'h0 - QUARTER_TURN))
      c = CMD_FWD;
    return c;
  endfunction

  // swap drive polarity, leave off and brake alone
  function automatic logic [1:0] flip_cmd(input logic [1:0] c);
    logic [1:0] r;
    r = c;
    if (c == CMD_FWD)
      r = CMD_REV;
    else if (c == CMD_REV)
      r = CMD_FWD;
    return r;
  endfunction

  function automatic int pbit(input int p, input int idx);
    return p * PAIR_BITS + idx;
  endfunction

  logic [IN_W-1:0] pins;
  logic            req;

  // pin gathering in the synchroniser's bit order
  assign pins = {drive_mode_sel0, chopper_oscillator, overcurrent_detect,
                 thermal_shutdown, sleep_n,
                 limit_hit_second_pair, blank_decay_sel_second_pair,
                 resolution_sel_lo_second_pair,
                 resolution_sel_hi_second_pair, direction_second_pair,
                 output_enable_second_pair, step_pulse_second_pair,
                 limit_hit_first_pair, blank_decay_sel_first_pair,
                 resolution_sel_lo_first_pair,
                 resolution_sel_hi_first_pair, direction_first_pair,
                 output_enable_first_pair, step_pulse_first_pair};

  assign req = read | write;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic            run;
    logic            osc_edge;
    logic            step_evt;
    logic            en;
    logic            dir;
    logic            limit_eff;
    logic [1:0]      res;
    logic [3:0]      inc;
    logic [3:0][1:0] tgt;
    logic [1:0]      dc_cmd;
    s_next    = s_reg;
    run       = 1'b0;
    osc_edge  = 1'b0;
    step_evt  = 1'b0;
    en        = 1'b0;
    dir       = 1'b0;
    limit_eff = 1'b0;
    res       = RES_FIXED;
    inc       = STEP_FULL;
    tgt       = '0;
    dc_cmd    = CMD_OFF;

    // three-stage synchroniser; a level counts once stages 2 and 3 agree
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    for (int i = 0; i < IN_W; i++) begin
      if (s_reg.sync2[i] == s_reg.sync3[i])
        s_next.filt[i] = s_reg.sync3[i];
    end
    s_next.prev = s_reg.filt;
    osc_edge = s_reg.filt[IDX_OSC] & ~s_reg.prev[IDX_OSC];

    // mode strap caught once after the chain has settled; not re-read until the next reset
    if (!s_reg.strap_done) begin
      s_next.strap_cnt = s_reg.strap_cnt + 3'h1;
      if (s_reg.strap_cnt == STRAP_LAST) begin
        s_next.strap_done = 1'b1;
        s_next.dc_mode    = ~s_reg.filt[IDX_DRIVE_MODE_SEL0];
      end
    end

    // power sequencing: sleep stops logic, wake waits the resume time
    unique case (s_reg.pwr)
      PWR_SLEEP: begin
        if (s_reg.filt[IDX_SLEEP]) begin
          s_next.pwr      = PWR_WAKE;
          s_next.wake_cnt = '0;
        end
      end
      PWR_WAKE: begin
        if (!s_reg.filt[IDX_SLEEP])
          s_next.pwr = PWR_SLEEP;
        else if (s_reg.wake_cnt == WAKE_W'(WAKE_CYCLES - 1))
          s_next.pwr = PWR_RUN;
        else
          s_next.wake_cnt = s_reg.wake_cnt + 1'b1;
      end
      PWR_RUN: begin
        if (!s_reg.filt[IDX_SLEEP])
          s_next.pwr = PWR_SLEEP;
      end
    endcase
    run = (s_reg.pwr == PWR_RUN) && s_reg.strap_done;

    // per pair: angle, bridge targets, blanking and decay
    for (int p = 0; p < 2; p++) begin
      step_evt = s_reg.filt[pbit(p, IDX_STEP)]
               & ~s_reg.prev[pbit(p, IDX_STEP)];
      en  = s_reg.filt[pbit(p, IDX_EN)] & s_reg.gate[p];
      dir = s_reg.filt[pbit(p, IDX_DIR)];
      res = {s_reg.filt[pbit(p, IDX_HI)], s_reg.filt[pbit(p, IDX_LO)]};
      if (!run || s_reg.dc_mode) begin
        s_next.angle[p] = ANGLE_INIT;
      end else if (res == RES_FIXED) begin
        s_next.angle[p] = ANGLE_INIT;
      end else if (step_evt) begin
        unique case (res)
          RES_HALF: inc = STEP_HALF;
          RES_FULL: inc = STEP_FULL;
          default:  inc = STEP_QUARTER;
        endcase
        // direction taken at the step edge itself
        if (dir)
          s_next.angle[p] = s_reg.angle[p] + inc;
        else
          s_next.angle[p] = s_reg.angle[p] - inc;
        s_next.step_cnt[p] = s_reg.step_cnt[p] + 16'h1;
      end

      if (!run) begin
        tgt[2*p]   = CMD_OFF;
        tgt[2*p+1] = CMD_OFF;
      end else if (s_reg.dc_mode) begin
        // in1 on the hi select, in2 on the lo select, brake on enable
        if (!s_reg.filt[pbit(p, IDX_EN)])
          dc_cmd = CMD_BRAKE;
        else begin
          unique case (res)
            2'h3:    dc_cmd = CMD_BRAKE;
            2'h1:    dc_cmd = CMD_REV;
            2'h2:    dc_cmd = CMD_FWD;
            default: dc_cmd = CMD_OFF;
          endcase
        end
        // software gate off overrides everything
        tgt[2*p]   = s_reg.gate[p] ? dc_cmd : CMD_OFF;
        tgt[2*p+1] = s_reg.gate[p] ? dc_cmd : CMD_OFF;
      end else if (!en) begin
        tgt[2*p]   = CMD_OFF;
        tgt[2*p+1] = CMD_OFF;
      end else begin
        // phase a follows cosine, inverted when dir is low, phase b sine; brake never produced
        tgt[2*p]   = phase_cmd(s_reg.angle[p]);
        tgt[2*p+1] = phase_cmd(s_reg.angle[p] - QUARTER_TURN);
        if (!dir)
          tgt[2*p] = flip_cmd(tgt[2*p]);
      end

      // blanking window: oscillator cycles in dc select, else analog
      limit_eff = s_reg.filt[pbit(p, IDX_LIM)] && (s_reg.blank[p] == '0);
      if (s_reg.blank[p] != '0 && (!s_reg.blank_osc[p] || osc_edge))
        s_next.blank[p] = s_reg.blank[p] - 1'b1;
      if (!run) begin
        s_next.decay[p] = DECAY_NONE;
        s_next.blank[p] = '0;
      end else if (s_reg.dc_mode) begin
        s_next.decay[p] = limit_eff ? DECAY_MIX_HI : DECAY_NONE;
      end else if (!s_reg.filt[pbit(p, IDX_BLK)]) begin
        s_next.decay[p] = DECAY_MIX_HI;
      end else begin
        // falling current is seen as the limit reached after blanking
        s_next.decay[p] = limit_eff ? DECAY_MIX_HI : DECAY_MIX_LO;
      end
    end

    // dead time: any change passes through off for a fixed gap
    for (int b = 0; b < 4; b++) begin
      if (s_reg.dead[b] != '0)
        s_next.dead[b] = s_reg.dead[b] - 1'b1;
      if (tgt[b] != s_reg.applied[b]) begin
        if (s_reg.applied[b] != CMD_OFF) begin
          s_next.applied[b] = CMD_OFF;
          s_next.dead[b]    = DEAD_CYCLES;
        end else if (s_reg.dead[b] == '0) begin
          s_next.applied[b] = tgt[b];
          // a fresh conduction phase opens a blanking window
          if (tgt[b] != CMD_OFF) begin
            if (s_reg.dc_mode && s_reg.filt[pbit(b / 2, IDX_BLK)]) begin
              s_next.blank[b/2]     = BLANK_OSC_CYC;
              s_next.blank_osc[b/2] = 1'b1;
            end else begin
              s_next.blank[b/2]     = ANALOG_BLANK;
              s_next.blank_osc[b/2] = 1'b0;
            end
          end
        end
      end
      s_next.outs[b].pos    = (s_next.applied[b] == CMD_FWD);
      s_next.outs[b].neg    = (s_next.applied[b] == CMD_REV);
      s_next.outs[b].pos_oe = (s_next.applied[b] != CMD_OFF);
      s_next.outs[b].neg_oe = (s_next.applied[b] != CMD_OFF);
    end

    // monitor and alert
    s_next.mon = run && !s_reg.dc_mode && (s_next.angle[0] == ANGLE_INIT);
    s_next.alert_oe = s_reg.filt[IDX_TSD] | s_reg.filt[IDX_ISD];

    // avalon slave: one wait cycle, read data registered at its end, write one cycle later
    s_next.ack = req & ~s_reg.ack;
    if (read && !s_reg.ack) begin
      unique case (address)
        REG_CTRL:   s_next.rdata = {30'h0, s_reg.gate};
        REG_STATUS: s_next.rdata = {12'h0, s_reg.angle[1], s_reg.angle[0],
                                    s_reg.decay[1], s_reg.decay[0],
                                    2'h0, s_reg.filt[IDX_ISD],
                                    s_reg.filt[IDX_TSD], s_reg.alert_oe,
                                    s_reg.dc_mode, s_reg.strap_done,
                                    (s_reg.pwr == PWR_RUN)};
        REG_STEPS:  s_next.rdata = {s_reg.step_cnt[1], s_reg.step_cnt[0]};
        default:    s_next.rdata = 32'h0;
      endcase
    end
    if (write && s_reg.ack && address == REG_CTRL && byteenable[0])
      s_next.gate = writedata[1:0];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      s_reg <= STATE_RESET;
    else
      s_reg <= s_next;
  end

  // outputs
  assign bridge_out               = s_reg.outs;
  assign decay_mode[0]            = decay_e'(s_reg.decay[0]);
  assign decay_mode[1]            = decay_e'(s_reg.decay[1]);
  assign angle_monitor_first_pair = s_reg.mon;
  assign fault_alert_o            = 1'b0;       // open drain: low or off
  assign fault_alert_oe           = s_reg.alert_oe;
  assign readdata                 = s_reg.rdata;
  assign waitrequest              = req & ~s_reg.ack;

endmodule

// ==== verif/motor_ctrl_checker_assertions.sv ====
// assertion checker for the dual motor control block
`timescale 1ns/1ns
module motor_ctrl_checker
  import motor_ctrl_pkg::*;
(
  input wire logic         mclk,                     // clock
  input wire logic         rst,                      // async reset
  input wire logic         sleep_n,                  // low power
  input wire logic         thermal_shutdown,         // fault
  input wire logic         overcurrent_detect,       // fault
  input wire logic         output_enable_first_pair, // enable
  input wire logic         drive_mode_sel0,          // strap
  input wire logic         read,                     // bus
  input wire logic         write,                    // bus
  input wire logic         waitrequest,              // bus stall
  input wire logic         fault_alert_o,            // alert level
  input wire logic         fault_alert_oe,           // alert drive
  input bridge_out_s [3:0] bridge_out                // bridges
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic fwd0, rev0, brk, pair_oe, any_oe, fault;
  // drive states; brake seen on either first-pair bridge
  assign fwd0    = bridge_out[0] == 4'hb;
  assign rev0    = bridge_out[0] == 4'h7;
  assign brk     = bridge_out[0] == 4'h3 || bridge_out[1] == 4'h3;
  assign pair_oe = |{bridge_out[0][1:0], bridge_out[1][1:0]};
  assign any_oe  = pair_oe | (|{bridge_out[2][1:0], bridge_out[3][1:0]});
  assign fault   = thermal_shutdown | overcurrent_detect;

  // ****************************************************************
  // properties; windows of 8 cover sync plus output latency
  // ****************************************************************
  a_sleep_off: assert property (
    (!sleep_n)[*8] |-> !any_oe) else $error("bridge driven in sleep");
  a_enable_off: assert property (
    (drive_mode_sel0 && !output_enable_first_pair)[*8] |-> !pair_oe)
    else $error("disabled pair still driven");
  a_no_brake: assert property (
    drive_mode_sel0 |-> !brk) else $error("short brake in stepper mode");
  a_dead_gap: assert property (
    (fwd0 ##1 !fwd0) |-> !rev0 [*3]) else $error("no dead time");
  a_alert_pull: assert property (
    fault [*8] |-> fault_alert_oe) else $error("alert not pulled");
  a_alert_free: assert property (
    (!fault) [*8] |-> !fault_alert_oe) else $error("alert stuck low");
  a_alert_level: assert property (
    fault_alert_oe |-> !fault_alert_o) else $error("alert drives high");
  a_wait_once: assert property (
    $rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("wait state count off");
  // main scenarios reached
  c_dir_flip: cover property (fwd0 ##[1:20] rev0);
  c_sleep: cover property ((!sleep_n)[*8]);
  c_fault: cover property (fault_alert_oe && fault);
endmodule

bind dual_motor_ctrl motor_ctrl_checker chk (
  .mclk(mclk), .rst(rst), .sleep_n(sleep_n),
  .thermal_shutdown(thermal_shutdown),
  .overcurrent_detect(overcurrent_detect),
  .output_enable_first_pair(output_enable_first_pair),
  .drive_mode_sel0(drive_mode_sel0), .read(read), .write(write),
  .waitrequest(waitrequest), .fault_alert_o(fault_alert_o),
  .fault_alert_oe(fault_alert_oe), .bridge_out(bridge_out));

// ==== verif/host_pins.sv ====
// host controller model driving the static control pins
`timescale 1ns/1ns
module host_pins
  import motor_ctrl_pkg::*;
(
  input  wire logic            mclk, // system clock
  output logic      [IN_W-1:0] pins  // control pins, package layout
);
  // all low from power-on: enables off, strap set before reset ends
  initial pins = '0;
  int osc_div = 0;
  // chopper reference at an eighth of the clock; each level must stand
  // two cycles or the pin filter never sees it change
  always @(posedge mclk) begin
    osc_div <= osc_div + 1;
    if (osc_div % 4 == 3)
      pins[IDX_OSC] <= ~pins[IDX_OSC];
  end
  // one level change, launched just after an edge
  task automatic set(input int idx, input logic v);
    @(posedge mclk);
    pins[idx] <= v;
  endtask
  // one step pulse; six cycles high and low, above the sync minimum
  task automatic step(input int pair);
    set(pair * PAIR_BITS + IDX_STEP, 1'b1);
    repeat (5) @(posedge mclk);
    set(pair * PAIR_BITS + IDX_STEP, 1'b0);
    repeat (5) @(posedge mclk);
  endtask
endmodule

// ==== verif/dual_motor_ctrl_bench.sv ====
// self-checking bench for the dual motor control block
`timescale 1ns/1ns
module dual_motor_ctrl_bench
  import motor_ctrl_pkg::*;
;
  logic              mclk, rst, read, write, waitrequest;
  logic              angle_mon, alert_o, alert_oe;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata, q;
  logic [IN_W-1:0]   pins;
  bridge_out_s [3:0] bridge_out;
  decay_e [1:0]      decay_mode;
  int                n_fail = 0, comparisons = 0, cycles = 0;
  localparam logic [3:0] FWD = 4'hb, REV = 4'h7, BRK = 4'h3, OFF = 4'h0;
  // {hi,lo}, steps, phase a, phase b; angle walks 2,2,4,6,10,12,2
  localparam logic [11:0] STEP_TAB [6] =
    '{12'h1bb, 12'h50b, 12'h57b, 12'h977, 12'he07, 12'h0bb};
  localparam logic [3:0] DC_TAB [4] = '{OFF, REV, FWD, BRK};

  host_pins host (.mclk(mclk), .pins(pins));
  dual_motor_ctrl #(.WAKE_CYCLES(8)) dut (
    .mclk(mclk), .rst(rst),
    .step_pulse_first_pair(pins[IDX_STEP]),
    .step_pulse_second_pair(pins[PAIR_BITS+IDX_STEP]),
    .output_enable_first_pair(pins[IDX_EN]),
    .output_enable_second_pair(pins[PAIR_BITS+IDX_EN]),
    .direction_first_pair(pins[IDX_DIR]),
    .direction_second_pair(pins[PAIR_BITS+IDX_DIR]),
    .resolution_sel_hi_first_pair(pins[IDX_HI]),
    .resolution_sel_lo_first_pair(pins[IDX_LO]),
    .resolution_sel_hi_second_pair(pins[PAIR_BITS+IDX_HI]),
    .resolution_sel_lo_second_pair(pins[PAIR_BITS+IDX_LO]),
    .blank_decay_sel_first_pair(pins[IDX_BLK]),
    .blank_decay_sel_second_pair(pins[PAIR_BITS+IDX_BLK]),
    .limit_hit_first_pair(pins[IDX_LIM]),
    .limit_hit_second_pair(pins[PAIR_BITS+IDX_LIM]),
    .chopper_oscillator(pins[IDX_OSC]),
    .thermal_shutdown(pins[IDX_TSD]), .overcurrent_detect(pins[IDX_ISD]),
    .sleep_n(pins[IDX_SLEEP]), .drive_mode_sel0(pins[IDX_DRIVE_MODE_SEL0]),
    .bridge_out(bridge_out), .decay_mode(decay_mode),
    .angle_monitor_first_pair(angle_mon), .fault_alert_o(alert_o),
    .fault_alert_oe(alert_oe), .address(address), .read(read),
    .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // whole run is under a thousand cycles; ceiling well above it
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // pos/neg levels mean nothing while a bridge is released
  function automatic logic [3:0] br(int b);
    return bridge_out[b][1:0] == 2'h0 ? OFF : bridge_out[b];
  endfunction
  // covers sync, wake time and dead time with margin
  task automatic settle;
    repeat (20) @(posedge mclk);
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    // look just before each edge: what that edge samples, clear of the
    // race with the slave's own update at the edge
    do begin
      @(negedge mclk);
      n++;
      done = (waitrequest === 1'b0);
      q = readdata;
      @(posedge mclk);
    end while (!done && n < 50);
    if (!done) n_fail++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic power_up(input logic strap);
    rst <= 1'b1;
    host.set(IDX_DRIVE_MODE_SEL0, strap);
    host.set(IDX_SLEEP, 1'b1);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    settle();
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic stepper_run;
    host.set(IDX_DIR, 1'b1);
    host.set(IDX_EN, 1'b1);
    for (int i = 0; i < 6; i++) begin
      host.set(IDX_HI, STEP_TAB[i][11]);
      host.set(IDX_LO, STEP_TAB[i][10]);
      repeat (STEP_TAB[i][9:8]) host.step(0);
      settle();
      check("phase a", br(0), STEP_TAB[i][7:4]);
      check("phase b", br(1), STEP_TAB[i][3:0]);
    end
    check("angle monitor", angle_mon, 1'b1);
    host.set(IDX_DIR, 1'b0);
    settle();
    check("ccw phase a", br(0), REV);
    settle();
    check("decay fixed", decay_mode[0], DECAY_MIX_HI);
    host.set(IDX_BLK, 1'b1);
    settle();
    check("decay mixed", decay_mode[0], DECAY_MIX_LO);
    host.set(IDX_EN, 1'b0);
    settle();
    check("disabled a", br(0), OFF);
    check("disabled b", br(1), OFF);
    check("second a", br(2), OFF);
    check("second decay", decay_mode[1], DECAY_MIX_HI);
    host.set(IDX_EN, 1'b1);
  endtask
  task automatic faults_and_sleep;
    for (int f = IDX_TSD; f <= IDX_ISD; f++) begin
      host.set(f, 1'b1);
      settle();
      check("alert pulled", alert_oe, 1'b1);
      host.set(f, 1'b0);
      settle();
      check("alert released", alert_oe, 1'b0);
    end
    host.set(IDX_SLEEP, 1'b0);
    settle();
    check("asleep", br(0), OFF);
    host.set(IDX_SLEEP, 1'b1);
    settle();
    check("awake", br(0), REV);
  endtask
  task automatic registers;
    bus(1'b0, REG_STATUS, 32'h0);
    check("status mode", q[2:1], 2'h1);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b0, REG_CTRL, 32'h0);
    check("ctrl gate", q, 32'h0);
    settle();
    check("gated a", br(0), OFF);
    bus(1'b1, REG_CTRL, 32'h3);
    bus(1'b0, 4'hc, 32'h0);
    check("unmapped", q, 32'h0);
  endtask
  task automatic dc_run;
    host.set(IDX_EN, 1'b0);
    host.set(IDX_BLK, 1'b0);
    power_up(1'b0);
    host.set(IDX_EN, 1'b1);
    for (int i = 0; i < 4; i++) begin
      host.set(IDX_HI, i[1]);
      host.set(IDX_LO, i[0]);
      settle();
      check("dc bridge a", br(0), DC_TAB[i]);
      check("dc bridge b", br(1), DC_TAB[i]);
    end
    host.set(IDX_EN, 1'b0);
    settle();
    check("pwm brake", br(0), BRK);
    host.set(IDX_LIM, 1'b1);
    settle();
    check("limit decay", decay_mode[0], DECAY_MIX_HI);
    host.set(IDX_BLK, 1'b1);
    host.set(IDX_EN, 1'b1);
    host.set(IDX_HI, 1'b0);
    // oscillator window far outlasts the analog one
    repeat (16) @(posedge mclk);
    check("osc blank", decay_mode[0], DECAY_NONE);
    settle();
    settle();
    check("blank over", decay_mode[0], DECAY_MIX_HI);
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    power_up(1'b1);
    stepper_run();
    faults_and_sleep();
    registers();
    dc_run();
    end_of_test();
  end
endmodule
